//--- design/t1rx_consts.svh
// Named constants for the T1 receive path control block.
`ifndef T1RX_CONSTS_SVH
`define T1RX_CONSTS_SVH
// What this block does
// - Minimum-delay caps elastic stores at 32 bits.
// - Minimum-delay mode disables slip contention logic.
// - Idle substitution writes 7F into marked channels.
// - Milliwatt substitution plays the eight-byte tone.
// - One config bit picks idle or milliwatt.
// - Three mark registers, one bit per channel.
// - Top three control bits select line build-out.
// - Gain limit bit picks -30dB or -36dB.
// - Depth bit: 0 is 128, 1 is 32.
// - Disable bit removes the attenuator entirely.
// - Power-down bit idles transmitter, tri-states both drivers.
// - Recovery uses crystal times 4, 32x oversampling.
// - On no signal, flag loss and probe alternate.
// - Loss picks clock source from table.
// - Receive-side attenuator restores near 50% duty.
`define T1RX_IDX_MARK1     8'h2d
`define T1RX_IDX_MARK2     8'h2e
`define T1RX_IDX_MARK3     8'h2f
`define T1RX_IDX_LIC       8'h7c
`define T1RX_IDX_CC3       8'h30
`define T1RX_IDX_RC2       8'h31
`define T1RX_IDX_STAT      8'h32
`define T1RX_REG_RST       8'h00
`define T1RX_CC3_MIN_DLY   7
`define T1RX_CC3_ES_RST    6
`define T1RX_RC2_MW_SEL    7
`define T1RX_LIC_BO_HI     7
`define T1RX_LIC_BO_LO     5
`define T1RX_LIC_EGL       4
`define T1RX_LIC_JAS       3
`define T1RX_LIC_JAD       2
`define T1RX_LIC_DJA       1
`define T1RX_LIC_TPD       0
`define T1RX_IDLE_CODE     8'h7f
`define T1RX_MW_0          8'h1e
`define T1RX_MW_1          8'h0b
`define T1RX_MW_2          8'h0b
`define T1RX_MW_3          8'h1e
`define T1RX_MW_4          8'h9e
`define T1RX_MW_5          8'h8b
`define T1RX_MW_6          8'h8b
`define T1RX_MW_7          8'h9e
`define T1RX_ES_DEPTH_MIN  9'h020
`define T1RX_ES_DEPTH_FULL 9'h182
`define T1RX_JA_DEPTH_DEEP 8'h80
`define T1RX_JA_DEPTH_SHAL 8'h20
`define T1RX_PLL_MULT      3'h4
`define T1RX_OVERSAMPLE    6'h20
`define T1RX_CH_FIRST      5'h01
`define T1RX_CH_LAST       5'h18
`define T1RX_ACLK_WINDOW   64
`endif

//--- design/t1rx_pkg.sv
// Types shared by the T1 receive path control block.
package t1rx_pkg;
    // Gray coded along the usual path from recovered clock outward.
    typedef enum logic [2:0] {
        T1RX_SRC_RECOVERED = 3'h0,
        T1RX_SRC_ALT_JA    = 3'h1,
        T1RX_SRC_ALT       = 3'h3,
        T1RX_SRC_CRYSTAL   = 3'h2,
        T1RX_SRC_TRANSMIT_CLOCK_JA   = 3'h6
    } t1rx_clk_src_e;

    typedef struct packed {
        logic       valid;
        logic       frame_start;
        logic [4:0] channel;
        logic [7:0] data;
    } t1rx_byte_s;

    typedef struct packed {
        logic [23:0] marks;
        logic [7:0]  lic;
        logic [7:0]  rc2;
        logic [7:0]  cc3;
    } t1rx_cfg_s;

    typedef struct packed {
        logic [2:0] buildout_sel;
        logic       equalizer_gain_limit;
        logic       ja_in_rx_path;
        logic       ja_in_tx_path;
        logic [7:0] ja_depth_bits;
        logic       duty_restored;
        logic       transmit_power_down;
    } t1rx_line_s;
endpackage

//--- design/t1rx_aclk_detect.sv
// Activity detector for the alternate clock input.
`timescale 1ns/100ps
`include "t1rx_consts.svh"
module t1rx_aclk_detect #(
    parameter int WINDOW = `T1RX_ACLK_WINDOW
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    input  wire logic aclk,
    output logic      present
);
    typedef struct packed {
        logic        prev;
        logic [15:0] idle_cnt;
        logic        present;
    } t1rx_det_s;

    t1rx_det_s q;
    t1rx_det_s d;

    // A pin tied low never toggles, so it cannot be mistaken for a clock.
    always_comb
    begin
        d      = q;
        d.prev = aclk;
        if (aclk != q.prev)
        begin
            d.idle_cnt = 16'h0000;
        end
        else if (q.idle_cnt < 16'(WINDOW))
        begin
            d.idle_cnt = q.idle_cnt + 16'h0001;
        end
        d.present = (d.idle_cnt < 16'(WINDOW));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '{prev: 1'b0, idle_cnt: 16'(WINDOW), present: 1'b0};
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    assign present = q.present;
endmodule // t1rx_aclk_detect

//--- design/t1rx_ctrl.sv
// Receive path control: registers, channel substitution, line setup, clock source.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "t1rx_consts.svh"
module t1rx_ctrl #(
    parameter int ACLK_WINDOW = `T1RX_ACLK_WINDOW
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire t1rx_pkg::t1rx_byte_s  rx_in,
    output t1rx_pkg::t1rx_byte_s       rx_out,
    input  wire logic                  line_signal_present,
    input  wire logic                  alternate_clock_input,
    output logic                       receive_carrier_loss,
    output t1rx_pkg::t1rx_clk_src_e    rx_clk_source,
    output logic [8:0]                 rx_store_depth,
    output logic [8:0]                 tx_store_depth,
    output logic                       slip_logic_enable,
    output logic                       store_reset_pulse,
    output t1rx_pkg::t1rx_line_s       line_ctrl,
    output logic                       line_drive_pos_oe,
    output logic                       line_drive_neg_oe,
    output logic [2:0]                 pll_multiplier,
    output logic [5:0]                 oversample_ratio
);
    import t1rx_pkg::*;

    typedef struct packed {
        t1rx_cfg_s     cfg;
        logic          wr_pend;
        logic [7:0]    wr_idx;
        logic          hready_o;
        logic [31:0]   rdata;
        logic          frame_seen;
        logic [2:0]    mw_phase;
        t1rx_byte_s    rx_o;
        logic          carrier_loss;
        t1rx_clk_src_e src;
        logic [8:0]    es_depth;
        logic          slip_en;
        logic          es_pulse;
        t1rx_line_s    line;
        logic          drv_oe;
        logic [2:0]    pll_mult;
        logic [5:0]    osr;
    } t1rx_state_s;

    t1rx_state_s q;
    t1rx_state_s d;
    logic        aclk_present;

    // Offsets are register indices; the byte address is four times the index.
    function automatic logic [7:0] ahb_index(input logic [31:0] addr);
        ahb_index = addr[9:2];
    endfunction

    function automatic t1rx_cfg_s cfg_write(
        input t1rx_cfg_s  c,
        input logic [7:0] idx,
        input logic [7:0] val
    );
        t1rx_cfg_s r;
        r = c;
        unique case (idx)
            `T1RX_IDX_MARK1: r.marks[7:0]   = val;
            `T1RX_IDX_MARK2: r.marks[15:8]  = val;
            `T1RX_IDX_MARK3: r.marks[23:16] = val;
            `T1RX_IDX_LIC:   r.lic          = val;
            `T1RX_IDX_CC3:   r.cc3          = val;
            `T1RX_IDX_RC2:   r.rc2          = val;
            default:         r              = c;
        endcase
        cfg_write = r;
    endfunction

    function automatic logic [31:0] reg_read(
        input logic [7:0] idx,
        input t1rx_cfg_s  c,
        input logic [7:0] stat
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `T1RX_IDX_MARK1: v = c.marks[7:0];
            `T1RX_IDX_MARK2: v = c.marks[15:8];
            `T1RX_IDX_MARK3: v = c.marks[23:16];
            `T1RX_IDX_LIC:   v = c.lic;
            `T1RX_IDX_CC3:   v = c.cc3;
            `T1RX_IDX_RC2:   v = c.rc2;
            `T1RX_IDX_STAT:  v = stat;
            default:         v = 8'h00;
        endcase
        reg_read = {24'h000000, v};
    endfunction

    function automatic logic [7:0] mw_byte(input logic [2:0] ph);
        logic [7:0] b;
        b = `T1RX_MW_0;
        unique case (ph)
            3'h0: b = `T1RX_MW_0;
            3'h1: b = `T1RX_MW_1;
            3'h2: b = `T1RX_MW_2;
            3'h3: b = `T1RX_MW_3;
            3'h4: b = `T1RX_MW_4;
            3'h5: b = `T1RX_MW_5;
            3'h6: b = `T1RX_MW_6;
            3'h7: b = `T1RX_MW_7;
        endcase
        mw_byte = b;
    endfunction

    function automatic logic ch_marked(input logic [23:0] m, input logic [4:0] ch);
        logic hit;
        hit = 1'b0;
        if (ch >= `T1RX_CH_FIRST && ch <= `T1RX_CH_LAST)
        begin
            hit = m[ch - `T1RX_CH_FIRST];
        end
        ch_marked = hit;
    endfunction

    t1rx_aclk_detect #(
        .WINDOW (ACLK_WINDOW)
    ) u_aclk (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .aclk    (alternate_clock_input),
        .present (aclk_present)
    );

    always_comb
    begin
        logic       take;
        logic [2:0] phase;
        logic       jitter_atten_side;
        logic       jitter_atten_disable;
        logic [7:0] stat;
        d     = q;
        take  = hsel && htrans[1] && hready;
        phase = q.mw_phase;
        jitter_atten_side   = 1'b0;
        jitter_atten_disable   = 1'b0;
        stat  = 8'h00;

        // Bus: the write lands in its data phase, so a read right behind it sees it.
        d.hready_o = 1'b1;
        d.es_pulse = 1'b0;
        if (q.wr_pend)
        begin
            d.cfg = cfg_write(q.cfg, q.wr_idx, hwdata[7:0]);
        end
        // Only the rising edge of the store reset bit restarts the stores.
        if (d.cfg.cc3[`T1RX_CC3_ES_RST] && !q.cfg.cc3[`T1RX_CC3_ES_RST])
        begin
            d.es_pulse = 1'b1;
        end
        d.wr_pend = 1'b0;
        if (take)
        begin
            d.wr_pend = hwrite;
            d.wr_idx  = ahb_index(haddr);
        end

        // Elastic store sizing and slip control.
        if (d.cfg.cc3[`T1RX_CC3_MIN_DLY])
        begin
            d.es_depth = `T1RX_ES_DEPTH_MIN;
            d.slip_en  = 1'b0;
        end
        else
        begin
            d.es_depth = `T1RX_ES_DEPTH_FULL;
            d.slip_en  = 1'b1;
        end

        // Line interface control fields.
        jitter_atten_side = d.cfg.lic[`T1RX_LIC_JAS];
        jitter_atten_disable = d.cfg.lic[`T1RX_LIC_DJA];
        d.line.buildout_sel         = d.cfg.lic[`T1RX_LIC_BO_HI:`T1RX_LIC_BO_LO];
        d.line.equalizer_gain_limit = d.cfg.lic[`T1RX_LIC_EGL];
        d.line.ja_in_rx_path        = !jitter_atten_disable && !jitter_atten_side;
        d.line.ja_in_tx_path        = !jitter_atten_disable && jitter_atten_side;
        if (d.cfg.lic[`T1RX_LIC_JAD])
        begin
            d.line.ja_depth_bits = `T1RX_JA_DEPTH_SHAL;
        end
        else
        begin
            d.line.ja_depth_bits = `T1RX_JA_DEPTH_DEEP;
        end
        // Only the receive-side attenuator smooths the oversampled clock.
        d.line.duty_restored       = !jitter_atten_disable && !jitter_atten_side;
        d.line.transmit_power_down = d.cfg.lic[`T1RX_LIC_TPD];
        d.drv_oe                   = !d.cfg.lic[`T1RX_LIC_TPD];
        d.pll_mult                 = `T1RX_PLL_MULT;
        d.osr                      = `T1RX_OVERSAMPLE;

        // Receive clock source; a disabled attenuator behaves as transmit-side.
        d.carrier_loss = !line_signal_present;
        if (!d.carrier_loss)
        begin
            d.src = T1RX_SRC_RECOVERED;
        end
        else if (aclk_present)
        begin
            d.src = (!jitter_atten_side && !jitter_atten_disable) ? T1RX_SRC_ALT_JA : T1RX_SRC_ALT;
        end
        else
        begin
            d.src = (!jitter_atten_side && !jitter_atten_disable) ? T1RX_SRC_CRYSTAL : T1RX_SRC_TRANSMIT_CLOCK_JA;
        end

        // Channel substitution on the receive byte stream.
        d.rx_o = rx_in;
        if (rx_in.valid && rx_in.frame_start)
        begin
            if (q.frame_seen)
            begin
                phase = q.mw_phase + 3'h1;
            end
            d.frame_seen = 1'b1;
            d.mw_phase   = phase;
        end
        if (rx_in.valid && ch_marked(d.cfg.marks, rx_in.channel))
        begin
            if (d.cfg.rc2[`T1RX_RC2_MW_SEL])
            begin
                d.rx_o.data = mw_byte(phase);
            end
            else
            begin
                d.rx_o.data = `T1RX_IDLE_CODE;
            end
        end
        if (!rx_in.valid)
        begin
            d.rx_o = '0;
        end

        // Status reflects the state this cycle is about to register.
        stat = {1'b0, d.line.duty_restored, d.slip_en, d.src, aclk_present, d.carrier_loss};
        if (take && !hwrite)
        begin
            d.rdata = reg_read(ahb_index(haddr), d.cfg, stat);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q            <= '0;
            q.cfg.lic    <= `T1RX_REG_RST;
            q.cfg.rc2    <= `T1RX_REG_RST;
            q.cfg.cc3    <= `T1RX_REG_RST;
            q.hready_o   <= 1'b1;
            q.src        <= T1RX_SRC_RECOVERED;
            q.es_depth   <= `T1RX_ES_DEPTH_FULL;
            q.slip_en    <= 1'b1;
            q.drv_oe     <= 1'b1;
            q.pll_mult   <= `T1RX_PLL_MULT;
            q.osr        <= `T1RX_OVERSAMPLE;
            q.line.ja_in_rx_path <= 1'b1;
            q.line.duty_restored <= 1'b1;
            q.line.ja_depth_bits <= `T1RX_JA_DEPTH_DEEP;
        end
        else if (ce)
        begin
            q <= d;
        end
    end

    // Every output except hresp, which is tied to 0, is a field of the state register.
    assign hreadyout            = q.hready_o;
    assign hresp                = 1'b0;
    assign hrdata               = q.rdata;
    assign rx_out               = q.rx_o;
    assign receive_carrier_loss = q.carrier_loss;
    assign rx_clk_source        = q.src;
    assign rx_store_depth       = q.es_depth;
    assign tx_store_depth       = q.es_depth;
    assign slip_logic_enable    = q.slip_en;
    assign store_reset_pulse    = q.es_pulse;
    assign line_ctrl            = q.line;
    assign line_drive_pos_oe    = q.drv_oe;
    assign line_drive_neg_oe    = q.drv_oe;
    assign pll_multiplier       = q.pll_mult;
    assign oversample_ratio     = q.osr;
endmodule // t1rx_ctrl

//--- sim/t1rx_ctrl_chk.sv
// Concurrent checks on the T1 receive path control ports.
`timescale 1ns/100ps
module t1rx_ctrl_chk (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    ce,
    input wire t1rx_pkg::t1rx_byte_s    rx_in,
    input wire t1rx_pkg::t1rx_byte_s    rx_out,
    input wire logic                    line_signal_present,
    input wire logic                    receive_carrier_loss,
    input wire t1rx_pkg::t1rx_clk_src_e rx_clk_source,
    input wire logic [8:0]              rx_store_depth,
    input wire logic [8:0]              tx_store_depth,
    input wire logic                    slip_logic_enable,
    input wire t1rx_pkg::t1rx_line_s    line_ctrl,
    input wire logic                    line_drive_pos_oe,
    input wire logic                    line_drive_neg_oe,
    input wire logic [2:0]              pll_multiplier,
    input wire logic [5:0]              oversample_ratio
);
    import t1rx_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_store_depth: assert property (
        rx_store_depth == tx_store_depth && rx_store_depth inside {9'h020, 9'h182})
        else $error("store depths wrong");
    a_slip_off: assert property (slip_logic_enable == (rx_store_depth != 9'h020))
        else $error("slip logic enable wrong");
    a_sub_codes: assert property (ce && rx_in.valid |=> rx_out.valid &&
        rx_out.channel == $past(rx_in.channel) && (rx_out.data == $past(rx_in.data) ||
        rx_out.data inside {8'h7f, 8'h1e, 8'h0b, 8'h9e, 8'h8b}))
        else $error("receive byte not passed or substituted");
    a_loss_flag: assert property (ce && $changed(line_signal_present) |=>
        receive_carrier_loss == !$past(line_signal_present))
        else $error("carrier loss flag wrong");
    a_src_normal: assert property (!receive_carrier_loss |-> rx_clk_source == T1RX_SRC_RECOVERED)
        else $error("source not recovered clock");
    a_src_table: assert property (receive_carrier_loss && $stable(line_ctrl) |->
        (line_ctrl.ja_in_rx_path ? rx_clk_source inside {T1RX_SRC_ALT_JA, T1RX_SRC_CRYSTAL}
        : rx_clk_source inside {T1RX_SRC_ALT, T1RX_SRC_TRANSMIT_CLOCK_JA}))
        else $error("loss source wrong");
    a_ja_paths: assert property (!(line_ctrl.ja_in_rx_path && line_ctrl.ja_in_tx_path) &&
        line_ctrl.duty_restored == line_ctrl.ja_in_rx_path && line_ctrl.ja_depth_bits inside {8'h80, 8'h20})
        else $error("attenuator outputs wrong");
    a_tx_tristate: assert property (line_ctrl.transmit_power_down == !line_drive_pos_oe &&
        line_drive_pos_oe == line_drive_neg_oe)
        else $error("driver enables wrong");
    a_pll_const: assert property (pll_multiplier == 3'h4 && oversample_ratio == 6'h20)
        else $error("recovery constants wrong");
    cover property (rx_out.valid && rx_out.data == 8'h9e);
    cover property (receive_carrier_loss && rx_clk_source == T1RX_SRC_ALT);
    cover property (rx_store_depth == 9'h020);
endmodule // t1rx_ctrl_chk

bind t1rx_ctrl t1rx_ctrl_chk chk_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .rx_in(rx_in),
    .rx_out(rx_out), .line_signal_present(line_signal_present), .receive_carrier_loss(receive_carrier_loss),
    .rx_clk_source(rx_clk_source), .rx_store_depth(rx_store_depth), .tx_store_depth(tx_store_depth),
    .slip_logic_enable(slip_logic_enable), .line_ctrl(line_ctrl), .line_drive_pos_oe(line_drive_pos_oe),
    .line_drive_neg_oe(line_drive_neg_oe), .pll_multiplier(pll_multiplier),
    .oversample_ratio(oversample_ratio));

//--- sim/t1rx_line_model.sv
// Line-side model: receive byte stream, carrier and alternate clock.
`timescale 1ns/100ps
module t1rx_line_model (
    input  wire logic            hclk,
    input  wire logic            sig_on,
    input  wire logic            alt_on,
    output t1rx_pkg::t1rx_byte_s rx_in,
    output logic                 line_signal_present,
    output logic                 alternate_clock_input
);
    import t1rx_pkg::*;
    initial
    begin
        rx_in = '0;
        alternate_clock_input = 1'b0;
    end
    assign line_signal_present = sig_on;
    // A silent alternate input is held low so that no clock is sensed.
    always @(posedge hclk)
        alternate_clock_input <= alt_on ? ~alternate_clock_input : 1'b0;
    // Frame starts come from the device side; no external sync is ever driven.
    // Bytes are paced by hclk, standing in for a backplane locked to the line.
    task automatic frames(input int n, input logic gap);
        for (int f = 0; f < n; f++)
            for (int c = 1; c <= 24; c++)
            begin
                rx_in <= {1'b1, c == 1, 5'(c), 8'h40 | 8'(c)};
                @(posedge hclk);
                if (gap)
                begin
                    rx_in <= {2'b0, ~rx_in.channel, ~rx_in.data};
                    @(posedge hclk);
                end
            end
        rx_in <= {2'b0, ~rx_in.channel, ~rx_in.data};
    endtask
endmodule // t1rx_line_model

//--- sim/t1rx_ctrl_tb_top.sv
// Self-checking bench for the T1 receive path control block.
`timescale 1ns/100ps
`include "t1rx_consts.svh"
module t1rx_ctrl_tb_top;
    import t1rx_pkg::*;
    logic          hclk = 1'b0;
    logic          hresetn = 1'b0;
    logic          hsel = 1'b0;
    logic [31:0]   haddr = 32'h0;
    logic [1:0]    htrans = 2'h0;
    logic          hwrite = 1'b0;
    logic [31:0]   hwdata = 32'h0;
    logic          sig_on = 1'b1;
    logic          alt_on = 1'b0;
    logic          hreadyout, loss, pd, nd, slip, lsp, aci, rsp, rst_p;
    logic          ce = 1'b1;
    int            pulses = 0;
    logic [31:0]   hrdata;
    t1rx_byte_s    rx_in, rx_out;
    t1rx_clk_src_e src;
    logic [8:0]    rxd, txd;
    t1rx_line_s    lc;
    int            errors = 0;
    int            checked = 0;
    int            cyc = 0;
    int            fr = -1;
    logic [23:0]   mk = '0;
    logic          mw = 1'b0;
    logic [7:0]    mwt [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};
    logic [7:0]    ll [3] = '{8'hb5, 8'h4a, 8'h08};
    t1rx_clk_src_e sx [4] = '{T1RX_SRC_CRYSTAL, T1RX_SRC_ALT_JA, T1RX_SRC_TRANSMIT_CLOCK_JA, T1RX_SRC_ALT};
    always #12.5 hclk = ~hclk;
    t1rx_line_model line_u (.hclk(hclk), .sig_on(sig_on), .alt_on(alt_on), .rx_in(rx_in),
        .line_signal_present(lsp), .alternate_clock_input(aci));
    t1rx_ctrl #(.ACLK_WINDOW(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(rsp), .hrdata(hrdata), .rx_in(rx_in), .rx_out(rx_out),
        .line_signal_present(lsp), .alternate_clock_input(aci), .receive_carrier_loss(loss),
        .rx_clk_source(src), .rx_store_depth(rxd), .tx_store_depth(txd), .slip_logic_enable(slip),
        .store_reset_pulse(rst_p), .line_ctrl(lc), .line_drive_pos_oe(pd), .line_drive_neg_oe(nd),
        .pll_multiplier(), .oversample_ratio());
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // The master waits on hready without assuming any latency.
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, i, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, i, d, r);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, i, 8'h00, r);
        chk($sformatf("register %h", i), {24'h0, e}, r);
        chk("response", 32'h0, {31'h0, rsp});
    endtask
    function automatic t1rx_line_s lx(input logic [7:0] v);
        lx = '{v[7:5], v[4], !v[3] && !v[1], v[3] && !v[1], v[2] ? 8'h20 : 8'h80, !v[3] && !v[1], v[0]};
    endfunction
    task automatic lic_case(input logic [7:0] v);
        wr(`T1RX_IDX_LIC, v);
        repeat (2) @(posedge hclk);
        chk("line control", {16'h0, lx(v)}, {16'h0, lc});
        chk("driver enables", {30'h0, ~v[0], ~v[0]}, {30'h0, pd, nd});
        rd(`T1RX_IDX_LIC, v);
    endtask
    // Outputs are looked at mid-cycle, away from the edge that launches them.
    always @(negedge hclk)
    begin
        if (rst_p === 1'b1)
            pulses++;
        if (rx_out.valid === 1'b1)
        begin
            fr = fr + (rx_out.frame_start ? 1 : 0);
            chk("rx byte", mk[rx_out.channel - 5'h1] ? (mw ? mwt[fr % 8] : 8'h7f) : 8'h40 | rx_out.channel,
                rx_out.data);
        end
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            errors++;
            conclude;
        end
    end
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 4; k++) rd(8'h2d + 8'(k / 3 * 76 + k), 8'h00);
        rd(8'h00, 8'h00);
        chk("depth", {9'h182, 9'h182, 1'b1}, {rxd, txd, slip});
        $display("test reset done");
        wr(`T1RX_IDX_CC3, 8'h80);
        repeat (2) @(posedge hclk);
        chk("depth", {9'h020, 9'h020, 1'b0}, {rxd, txd, slip});
        wr(`T1RX_IDX_CC3, 8'hc0);
        wr(`T1RX_IDX_CC3, 8'h00);
        repeat (2) @(posedge hclk);
        chk("depth", {9'h182, 9'h182, 1'b1}, {rxd, txd, slip});
        chk("store reset pulses", 32'h1, pulses);
        $display("test min_delay done");
        mk = 24'h808005;
        for (int k = 0; k < 3; k++) wr(`T1RX_IDX_MARK1 + 8'(k), mk[8*k +: 8]);
        for (int k = 0; k < 3; k++) rd(`T1RX_IDX_MARK1 + 8'(k), mk[8*k +: 8]);
        line_u.frames(2, 1'b0);
        repeat (2) @(posedge hclk);
        wr(`T1RX_IDX_RC2, 8'h80);
        mw = 1'b1;
        line_u.frames(9, 1'b1);
        repeat (2) @(posedge hclk);
        $display("test substitution done");
        for (int k = 0; k < 3; k++) lic_case(ll[k]);
        $display("test line control done");
        for (int k = 0; k < 4; k++)
        begin
            lic_case({4'h0, k[1] == 1'b1, 3'h0});
            alt_on <= k[0];
            sig_on <= 1'b0;
            repeat (30) @(posedge hclk);
            chk("loss source", {28'h0, 1'b1, sx[k]}, {28'h0, loss, src});
            rd(`T1RX_IDX_STAT, {1'b0, !k[1], 1'b1, sx[k], k[0], 1'b1});
            sig_on <= 1'b1;
            repeat (3) @(posedge hclk);
            chk("loss source", 32'h0, {28'h0, loss, src});
        end
        $display("test carrier loss done");
        ce <= 1'b0;
        sig_on <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("frozen loss", 32'h0, {31'h0, loss});
        ce <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("released loss", 32'h1, {31'h0, loss});
        sig_on <= 1'b1;
        repeat (2) @(posedge hclk);
        $display("test clock enable done");
        conclude;
    end
endmodule // t1rx_ctrl_tb_top
